/* File: design/pms_pkg.sv */
package pms_pkg;

  // ************************************************************
  // Register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [7:0] PMS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PMS_STATUS_OFS = 8'h04;
  localparam logic [7:0] PMS_IRQ_STS_OFS = 8'h08;
  localparam logic [7:0] PMS_IRQ_MASK_OFS = 8'h0C;
  localparam int PMS_ADDR_W = 8;

  // ************************************************************
  // Field layouts
  // ************************************************************
  localparam int PMS_CTRL_W = 8;
  localparam int PMS_WUF_CLR_BIT = 8;
  localparam int PMS_STS_W = 4;
  localparam int PMS_IRQ_W = 2;
  localparam int PMS_IRQ_DET = 0;
  localparam int PMS_IRQ_WAKE = 1;
  localparam int PMS_BOR_W = 2;
  localparam int PMS_THR_W = 3;
  localparam int PMS_VOS_W = 2;

  typedef struct packed {
    logic lowpower;
    logic powerdown;
    logic [PMS_VOS_W-1:0] vscale;
    logic [PMS_THR_W-1:0] threshold;
    logic enable;
  } pms_ctrl_t;

  typedef struct packed {
    logic [PMS_BOR_W-1:0] bor_level;
    logic wakeup_flag;
    logic detector_flag;
  } pms_sts_t;

  // Analog comparator bundle, synchronised as one word
  typedef struct packed {
    logic detector_low;
    logic brownout_low;
    logic poweron_low;
  } pms_analog_t;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam pms_ctrl_t PMS_CTRL_RST = '0;
  localparam logic [PMS_IRQ_W-1:0] PMS_IRQ_RST = 2'h0;
  localparam logic [PMS_BOR_W-1:0] PMS_BOR_OFF = 2'h0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int PMS_CLK_PERIOD_NS = 8;
  localparam int PMS_WAKE_RESET_NS = 1000;
  localparam int PMS_WAKE_RESET_CYC =
    (PMS_WAKE_RESET_NS + PMS_CLK_PERIOD_NS - 1) / PMS_CLK_PERIOD_NS;
  localparam int PMS_CNT_W = $clog2(PMS_WAKE_RESET_CYC + 1);

  // ************************************************************
  // Power modes
  // ************************************************************
  typedef enum logic [4:0] {
    PMS_RUN = 5'h01,
    PMS_SLEEP = 5'h02,
    PMS_STOP = 5'h04,
    PMS_STANDBY = 5'h08,
    PMS_WAKE_RST = 5'h10
  } pms_state_t;

endpackage : pms_pkg

/* File: design/pms_power_mode_supervisor.sv */
// Summary of operation
// - Hold chip reset while power-on detector low
// - Hold chip reset while brown-out detector low
// - Option-byte brown-out level; zero disables it
// - Detector works only while enable set
// - Three-bit threshold select drives detector
// - Status flag shows supply below threshold
// - Event on threshold crossing either direction
// - Detector interrupt only when enabled
// - Run mode drives regulator scale from control
// - Stop gates clocks, holds regulator level
// - Standby removes core-domain power
// - Light sleep stops core clock only
// - Deep sleep stop halts clocks, oscillators
// - Standby exits on listed wake sources
// - Stop regulator low-power per control bit
// - Standby only when wake flag clear
// - Standby wake acts as chip reset
//
// Added by the designer: the placing of the registers and the APB slave port.
module pms_power_mode_supervisor
  import pms_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PMS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog supply monitors
  input wire pms_analog_t analog_low,
  input wire logic [PMS_BOR_W-1:0] opt_bor_level,
  output logic [PMS_BOR_W-1:0] brownout_level,
  output logic level_detector_enable,
  output logic [PMS_THR_W-1:0] detector_threshold_select,
  // Core requests and wake sources
  input wire logic core_wfi,
  input wire logic core_wfe,
  input wire logic core_deep_sleep_bit,
  input wire logic core_irq_pending,
  input wire logic core_event,
  input wire logic ext_irq,
  input wire logic wakeup_pin,
  input wire logic rtc_event,
  input wire logic external_reset_pin_n,
  input wire logic independent_watchdog_rst,
  // Power and clock controls
  output logic chip_reset_n,
  output logic core_clk_en,
  output logic sys_clk_en,
  output logic fast_osc_en,
  output logic core_power_en,
  output logic regulator_lowpower,
  output logic [PMS_VOS_W-1:0] regulator_voltage_scale,
  output logic irq
);

  // ************************************************************
  // Comparator synchronisation
  // ************************************************************
  pms_analog_t ana_s;

  pms_sync #(.W($bits(pms_analog_t))) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_i(analog_low),
    .sync_o(ana_s)
  );

  // ************************************************************
  // State
  // ************************************************************
  pms_ctrl_t ctrl_q, ctrl_d;
  logic [PMS_IRQ_W-1:0] irq_sts_q, irq_sts_d, irq_mask_q, irq_mask_d;
  logic [PMS_BOR_W-1:0] bor_lvl_q, bor_lvl_d;
  logic det_flag_q, det_flag_d, det_en_q, wuf_q, wuf_d, wakeup_pin_prev_q;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, irq_d;
  pms_state_t st_q, st_d;
  logic wfe_mode_q, wfe_mode_d;
  logic [PMS_CNT_W-1:0] cnt_q, cnt_d;
  logic rst_n_d, core_clk_d, sys_clk_d, osc_d, pwr_d, lp_d;
  logic [PMS_VOS_W-1:0] vos_d;
  logic setup, access_wr, access_rd, hit, det_evt, wake_evt;
  logic wakeup_pin_rise, standby_wake, bor_hold;
  pms_sts_t sts;

  assign setup = psel && !penable;
  assign access_wr = psel && penable && pready && pwrite;
  assign access_rd = psel && penable && pready && !pwrite;
  assign hit = paddr == PMS_CTRL_OFS || paddr == PMS_STATUS_OFS ||
               paddr == PMS_IRQ_STS_OFS || paddr == PMS_IRQ_MASK_OFS;
  assign wakeup_pin_rise = wakeup_pin && !wakeup_pin_prev_q;
  assign standby_wake = wakeup_pin_rise || rtc_event || !external_reset_pin_n || independent_watchdog_rst;
  assign bor_hold = bor_lvl_q != PMS_BOR_OFF && ana_s.brownout_low;

  // ************************************************************
  // Supply detector, status and bus
  // ************************************************************
  always_comb begin
    ctrl_d = ctrl_q;
    irq_mask_d = irq_mask_q;
    bor_lvl_d = opt_bor_level;
    det_flag_d = ctrl_q.enable && ana_s.detector_low;
    // Crossing only counts once the detector was already running
    det_evt = ctrl_q.enable && det_en_q && (det_flag_d != det_flag_q);
    wuf_d = wuf_q;
    // Cleared by a control write with the extra bit; a set in the same cycle wins
    if (access_wr && paddr == PMS_CTRL_OFS && pwdata[PMS_WUF_CLR_BIT]) begin
      wuf_d = 1'b0;
    end
    if (wakeup_pin_rise || rtc_event) begin
      wuf_d = 1'b1;
    end
    irq_sts_d = irq_sts_q;
    // Clear only the bits that the reader actually saw
    if (access_rd && paddr == PMS_IRQ_STS_OFS) begin
      irq_sts_d = irq_sts_q & ~prdata[PMS_IRQ_W-1:0];
    end
    irq_sts_d[PMS_IRQ_DET] = irq_sts_d[PMS_IRQ_DET] | det_evt;
    irq_sts_d[PMS_IRQ_WAKE] = irq_sts_d[PMS_IRQ_WAKE] | wake_evt;
    if (access_wr && paddr == PMS_CTRL_OFS) begin
      ctrl_d = pms_ctrl_t'(pwdata[PMS_CTRL_W-1:0]);
    end
    if (access_wr && paddr == PMS_IRQ_MASK_OFS) begin
      irq_mask_d = pwdata[PMS_IRQ_W-1:0];
    end
    irq_d = |(irq_sts_d & irq_mask_d);
    sts = '{bor_level: bor_lvl_q, wakeup_flag: wuf_q, detector_flag: det_flag_q};
    prdata_d = 32'h0000_0000;
    pready_d = setup;
    pslverr_d = setup && !hit;
    if (setup) begin
      case (paddr)
        PMS_CTRL_OFS: prdata_d = {{(32-PMS_CTRL_W){1'b0}}, ctrl_q};
        PMS_STATUS_OFS: prdata_d = {{(32-PMS_STS_W){1'b0}}, sts};
        PMS_IRQ_STS_OFS: prdata_d = {{(32-PMS_IRQ_W){1'b0}}, irq_sts_q};
        PMS_IRQ_MASK_OFS: prdata_d = {{(32-PMS_IRQ_W){1'b0}}, irq_mask_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= PMS_CTRL_RST;
      irq_sts_q <= PMS_IRQ_RST;
      irq_mask_q <= PMS_IRQ_RST;
      bor_lvl_q <= PMS_BOR_OFF;
      det_flag_q <= 1'b0;
      det_en_q <= 1'b0;
      wuf_q <= 1'b0;
      wakeup_pin_prev_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      brownout_level <= PMS_BOR_OFF;
      level_detector_enable <= 1'b0;
      detector_threshold_select <= 3'h0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_sts_q <= irq_sts_d;
      irq_mask_q <= irq_mask_d;
      bor_lvl_q <= bor_lvl_d;
      det_flag_q <= det_flag_d;
      det_en_q <= ctrl_q.enable;
      wuf_q <= wuf_d;
      wakeup_pin_prev_q <= wakeup_pin;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      irq <= irq_d;
      brownout_level <= bor_lvl_d;
      level_detector_enable <= ctrl_d.enable;
      detector_threshold_select <= ctrl_d.threshold;
    end
  end

  // ************************************************************
  // Low-power mode sequencer
  // ************************************************************
  always_comb begin
    st_d = st_q;
    wfe_mode_d = wfe_mode_q;
    cnt_d = cnt_q;
    wake_evt = 1'b0;
    case (st_q)
      PMS_RUN: begin
        if (core_wfi || core_wfe) begin
          wfe_mode_d = core_wfe && !core_wfi;
          if (!core_deep_sleep_bit) begin
            st_d = PMS_SLEEP;
          end else if (!ctrl_q.powerdown) begin
            st_d = PMS_STOP;
          end else if (!wuf_q) begin
            st_d = PMS_STANDBY;
          end
        end
      end
      PMS_SLEEP: begin
        if (wfe_mode_q ? core_event : core_irq_pending) begin
          st_d = PMS_RUN;
          wake_evt = 1'b1;
        end
      end
      PMS_STOP: begin
        if (ext_irq || (wfe_mode_q && core_event)) begin
          st_d = PMS_RUN;
          wake_evt = 1'b1;
        end
      end
      PMS_STANDBY: begin
        if (standby_wake) begin
          st_d = PMS_WAKE_RST;
          cnt_d = PMS_CNT_W'(PMS_WAKE_RESET_CYC - 1);
        end
      end
      PMS_WAKE_RST: begin
        if (cnt_q == '0) begin
          st_d = PMS_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: st_d = PMS_RUN;
    endcase
    rst_n_d = !(ana_s.poweron_low || bor_hold || st_d == PMS_WAKE_RST);
    core_clk_d = st_d == PMS_RUN || st_d == PMS_WAKE_RST;
    sys_clk_d = !(st_d == PMS_STOP || st_d == PMS_STANDBY);
    osc_d = sys_clk_d;
    pwr_d = st_d != PMS_STANDBY;
    lp_d = 1'b0;
    if (st_d == PMS_STOP) begin
      lp_d = st_q == PMS_STOP ? regulator_lowpower : ctrl_q.lowpower;
    end
    vos_d = st_d == PMS_RUN ? ctrl_q.vscale : regulator_voltage_scale;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= PMS_RUN;
      wfe_mode_q <= 1'b0;
      cnt_q <= '0;
      chip_reset_n <= 1'b0;
      core_clk_en <= 1'b1;
      sys_clk_en <= 1'b1;
      fast_osc_en <= 1'b1;
      core_power_en <= 1'b1;
      regulator_lowpower <= 1'b0;
      regulator_voltage_scale <= 2'h0;
    end else begin
      st_q <= st_d;
      wfe_mode_q <= wfe_mode_d;
      cnt_q <= cnt_d;
      chip_reset_n <= rst_n_d;
      core_clk_en <= core_clk_d;
      sys_clk_en <= sys_clk_d;
      fast_osc_en <= osc_d;
      core_power_en <= pwr_d;
      regulator_lowpower <= lp_d;
      regulator_voltage_scale <= vos_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence stop_req_s;
    st_q == PMS_RUN && core_wfi && core_deep_sleep_bit && !ctrl_q.powerdown;
  endsequence

  sequence stop_entered_s;
    st_q == PMS_STOP && !sys_clk_en && !fast_osc_en && !core_clk_en;
  endsequence

  por_hold_a: assert property (ana_s.poweron_low |=> !chip_reset_n)
    else $error("chip reset released during power-on low");
  bor_hold_a: assert property (bor_lvl_q != PMS_BOR_OFF && ana_s.brownout_low |=> !chip_reset_n)
    else $error("chip reset released during brown-out");
  bor_off_a: assert property (st_q == PMS_RUN && $past(st_q) == PMS_RUN && bor_lvl_q == PMS_BOR_OFF
      && !ana_s.poweron_low |=> chip_reset_n)
    else $error("brown-out reset acted while disabled");
  det_off_a: assert property (!ctrl_q.enable |=> !det_flag_q)
    else $error("detector flag set while disabled");
  det_event_a: assert property (ctrl_q.enable && det_en_q && $changed(det_flag_d) |=> irq_sts_q[PMS_IRQ_DET])
    else $error("detector crossing not recorded");
  irq_gate_a: assert property (((irq_sts_q | {wake_evt, det_evt}) & irq_mask_d) == '0 |=> !irq)
    else $error("interrupt raised while masked");
  scale_run_a: assert property (st_q == PMS_RUN ##1 st_q == PMS_RUN
      |-> regulator_voltage_scale == $past(ctrl_q.vscale))
    else $error("regulator scale not following control");
  scale_stop_a: assert property (st_q == PMS_STOP && $past(st_q) == PMS_STOP
      |-> $stable(regulator_voltage_scale))
    else $error("regulator scale changed in stop");
  standby_pwr_a: assert property (st_q == PMS_STANDBY |-> !core_power_en && !sys_clk_en)
    else $error("core domain powered in standby");
  sleep_clk_a: assert property (st_q == PMS_SLEEP |-> !core_clk_en && sys_clk_en && fast_osc_en)
    else $error("sleep gating wrong");
  stop_entry_a: assert property (stop_req_s |=> stop_entered_s)
    else $error("stop entry did not halt clocks");
  stop_lp_a: assert property (stop_req_s |=> regulator_lowpower == $past(ctrl_q.lowpower))
    else $error("stop regulator mode wrong");
  standby_flag_a: assert property (st_q == PMS_RUN && core_wfi && core_deep_sleep_bit
      && ctrl_q.powerdown && wuf_q |=> st_q == PMS_RUN)
    else $error("standby entered with wake flag set");
  standby_wake_a: assert property (st_q == PMS_STANDBY && standby_wake
      |=> st_q == PMS_WAKE_RST && !chip_reset_n && core_power_en)
    else $error("standby wake did not reset chip");
  wake_len_a: assert property ($rose(st_q == PMS_WAKE_RST) |-> (!chip_reset_n) [*8])
    else $error("wake reset pulse too short");

endmodule : pms_power_mode_supervisor

/* File: design/pms_sync.sv */
module pms_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : pms_sync

/* File: testbench/pms_core_model.sv */
module pms_core_model (
  // Clock
  input wire logic pclk,
  // Sleep requests and wake signals toward the supervisor
  output logic core_wfi,
  output logic core_wfe,
  output logic core_deep_sleep_bit,
  output logic core_irq_pending,
  output logic core_event
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    core_wfi = 1'b0;
    core_wfe = 1'b0;
    core_deep_sleep_bit = 1'b0;
    core_irq_pending = 1'b0;
    core_event = 1'b0;
  end

  // ************************************************************
  // Requests
  // ************************************************************
  // Deep bit settles a full cycle before the pulse, as a real core would
  task automatic request(input logic wfe, input logic deep);
    @(posedge pclk);
    core_deep_sleep_bit <= deep;
    @(posedge pclk);
    if (wfe) begin
      core_wfe <= 1'b1;
    end else begin
      core_wfi <= 1'b1;
    end
    @(posedge pclk);
    core_wfi <= 1'b0;
    core_wfe <= 1'b0;
  endtask : request

  // Interrupt wakes a WFI sleep, an event wakes a WFE sleep
  task automatic wake(input logic wfe);
    @(posedge pclk);
    if (wfe) begin
      core_event <= 1'b1;
    end else begin
      core_irq_pending <= 1'b1;
    end
    @(posedge pclk);
    core_event <= 1'b0;
    core_irq_pending <= 1'b0;
  endtask : wake
endmodule : pms_core_model

/* File: testbench/pms_power_mode_supervisor_tb.sv */
module pms_power_mode_supervisor_tb import pms_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chip_reset_n, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e;
  pms_analog_t analog_low;
  logic [1:0] opt_bor_level, brownout_level, regulator_voltage_scale;
  logic level_detector_enable, regulator_lowpower, core_clk_en, sys_clk_en, fast_osc_en, core_power_en;
  logic [2:0] detector_threshold_select;
  logic core_wfi, core_wfe, core_deep_sleep_bit, core_irq_pending, core_event;
  logic ext_irq, wakeup_pin, rtc_event, external_reset_pin_n, independent_watchdog_rst;
  int errors, n_tests, i, n;

  pms_core_model core (.pclk(pclk), .core_wfi(core_wfi), .core_wfe(core_wfe),
    .core_deep_sleep_bit(core_deep_sleep_bit), .core_irq_pending(core_irq_pending), .core_event(core_event));

  pms_power_mode_supervisor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_low(analog_low), .opt_bor_level(opt_bor_level), .brownout_level(brownout_level),
    .level_detector_enable(level_detector_enable), .detector_threshold_select(detector_threshold_select),
    .core_wfi(core_wfi), .core_wfe(core_wfe), .core_deep_sleep_bit(core_deep_sleep_bit),
    .core_irq_pending(core_irq_pending), .core_event(core_event), .ext_irq(ext_irq), .wakeup_pin(wakeup_pin),
    .rtc_event(rtc_event), .external_reset_pin_n(external_reset_pin_n),
    .independent_watchdog_rst(independent_watchdog_rst), .chip_reset_n(chip_reset_n),
    .core_clk_en(core_clk_en), .sys_clk_en(sys_clk_en), .fast_osc_en(fast_osc_en),
    .core_power_en(core_power_en), .regulator_lowpower(regulator_lowpower),
    .regulator_voltage_scale(regulator_voltage_scale), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask : tick

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      errors++;
      tally_and_finish();
    end
  endtask : apb

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, r, exp);
  endtask : rd

  // Comparator change, then enough edges for the two-flop synchroniser
  task automatic ana(input logic [2:0] v);
    analog_low <= pms_analog_t'(v);
    tick(6);
  endtask : ana

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    {psel, penable, pwrite, ext_irq, wakeup_pin, rtc_event, independent_watchdog_rst} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    analog_low = '0;
    opt_bor_level = 2'h0;
    external_reset_pin_n = 1'b1;
    errors = 0;
    n_tests = 0;
    presetn = 1'b0;
    tick(6);
    presetn <= 1'b1;
    tick(2);
    chk("chip_reset_n", 32'(chip_reset_n), 32'h1);
    rd("ctrl", PMS_CTRL_OFS, 32'h0);
    rd("status", PMS_STATUS_OFS, 32'h0);
    rd("irq_sts", PMS_IRQ_STS_OFS, 32'h0);
    rd("irq_mask", PMS_IRQ_MASK_OFS, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'(e), 32'h1);
    chk("unmapped_data", r, 32'h0);
    ana(3'h1);
    chk("por_reset", 32'(chip_reset_n), 32'h0);
    ana(3'h0);
    chk("por_release", 32'(chip_reset_n), 32'h1);
    for (i = 0; i < 4; i++) begin
      opt_bor_level <= 2'(i);
      ana(3'h2);
      chk("brownout_level", 32'(brownout_level), 32'(i));
      chk("bor_reset", 32'(chip_reset_n), 32'(i == 0));
      rd("status_bor", PMS_STATUS_OFS, 32'(i << 2));
      ana(3'h0);
      chk("bor_release", 32'(chip_reset_n), 32'h1);
    end
    opt_bor_level <= 2'h0;
    $display("test reset_monitors done");
    ana(3'h4);
    ana(3'h0);
    rd("det_disabled", PMS_IRQ_STS_OFS, 32'h0);
    apb(1'b1, PMS_IRQ_MASK_OFS, 32'h1);
    apb(1'b1, PMS_CTRL_OFS, 32'h2B);
    tick(2);
    chk("det_enable", 32'(level_detector_enable), 32'h1);
    chk("threshold", 32'(detector_threshold_select), 32'h5);
    chk("vscale", 32'(regulator_voltage_scale), 32'h2);
    ana(3'h4);
    rd("flag_low", PMS_STATUS_OFS, 32'h1);
    chk("irq_on", 32'(irq), 32'h1);
    rd("fall_evt", PMS_IRQ_STS_OFS, 32'h1);
    tick(2);
    chk("irq_clear", 32'(irq), 32'h0);
    ana(3'h0);
    rd("flag_high", PMS_STATUS_OFS, 32'h0);
    rd("rise_evt", PMS_IRQ_STS_OFS, 32'h1);
    apb(1'b1, PMS_IRQ_MASK_OFS, 32'h0);
    ana(3'h4);
    chk("irq_masked", 32'(irq), 32'h0);
    rd("masked_evt", PMS_IRQ_STS_OFS, 32'h1);
    ana(3'h0);
    rd("masked_rise", PMS_IRQ_STS_OFS, 32'h1);
    $display("test detector done");
    for (i = 0; i < 2; i++) begin
      core.request(1'(i), 1'b0);
      tick(1);
      chk("sleep_core", 32'(core_clk_en), 32'h0);
      chk("sleep_sys", 32'({sys_clk_en, fast_osc_en}), 32'h3);
      core.wake(1'(i));
      tick(1);
      chk("sleep_wake", 32'(core_clk_en), 32'h1);
      rd("sleep_irq", PMS_IRQ_STS_OFS, 32'h2);
    end
    $display("test sleep done");
    for (i = 0; i < 2; i++) begin
      apb(1'b1, PMS_CTRL_OFS, (i == 1) ? 32'hAB : 32'h2B);
      core.request(1'(i), 1'b1);
      tick(1);
      chk("stop_clks", 32'({sys_clk_en, fast_osc_en, core_clk_en}), 32'h0);
      chk("stop_lowpower", 32'(regulator_lowpower), 32'(i));
      apb(1'b1, PMS_CTRL_OFS, (i == 1) ? 32'h9B : 32'h1B);
      chk("stop_vscale", 32'(regulator_voltage_scale), 32'h2);
      // Second pass enters by WFE and wakes by an event instead of an interrupt
      if (i == 1) begin
        core.wake(1'b1);
      end else begin
        ext_irq <= 1'b1;
        tick(1);
        ext_irq <= 1'b0;
      end
      tick(1);
      chk("stop_wake", 32'({sys_clk_en, fast_osc_en, core_clk_en}), 32'h7);
      chk("run_lowpower", 32'(regulator_lowpower), 32'h0);
      chk("run_vscale", 32'(regulator_voltage_scale), 32'h1);
      rd("stop_irq", PMS_IRQ_STS_OFS, 32'h2);
    end
    $display("test stop done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, PMS_CTRL_OFS, 32'h140);
      core.request(1'b0, 1'b1);
      tick(1);
      chk("standby_power", 32'(core_power_en), 32'h0);
      case (i)
        0: wakeup_pin <= 1'b1;
        1: rtc_event <= 1'b1;
        2: external_reset_pin_n <= 1'b0;
        default: independent_watchdog_rst <= 1'b1;
      endcase
      tick(1);
      rtc_event <= 1'b0;
      external_reset_pin_n <= 1'b1;
      independent_watchdog_rst <= 1'b0;
      for (n = 0; n < 50 && chip_reset_n !== 1'b0; n++) tick(1);
      chk("wake_reset", 32'(chip_reset_n), 32'h0);
      if (chip_reset_n !== 1'b0) tally_and_finish();
      for (n = 0; n < 300 && chip_reset_n === 1'b0; n++) tick(1);
      chk("reset_len", 32'(n >= PMS_WAKE_RESET_CYC - 1 && n <= PMS_WAKE_RESET_CYC + 1), 32'h1);
      if (n == 300) tally_and_finish();
      chk("wake_power", 32'({core_power_en, chip_reset_n}), 32'h3);
      wakeup_pin <= 1'b0;
      if (i < 2) rd("wake_flag", PMS_STATUS_OFS, 32'h2);
      if (i == 0) begin
        core.request(1'b0, 1'b1);
        tick(1);
        chk("flag_blocks", 32'(core_power_en), 32'h1);
      end
    end
    $display("test standby done");
    tally_and_finish();
  end
endmodule : pms_power_mode_supervisor_tb
